// ---- rtl/tsi_pkg.sv ----
package tsi_pkg;

   // ---------------------------------------------
   // bus constants
   // ---------------------------------------------
   localparam logic [7:0] DEV_WR   = 8'ha2;
   localparam logic [7:0] DEV_RD   = 8'ha3;
   localparam logic [3:0] BYTE_LEN = 4'h8;
   localparam logic [3:0] TX_LAST  = 4'h7;
   localparam logic [7:0] PTR_RST  = 8'h00;

   // ---------------------------------------------
   // timeout
   // ---------------------------------------------
   localparam int unsigned TMO_MS  = 950;
   localparam int unsigned REF_HZ  = 32768;
   localparam int unsigned TMO_CYC = (TMO_MS * REF_HZ + 999) / 1000;

   // ---------------------------------------------
   // types
   // ---------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RXB  = 3'h1,
      ST_AOUT = 3'h3,
      ST_TXB  = 3'h2,
      ST_AIN  = 3'h6,
      ST_TMO  = 3'h4
   } tsi_state_t;

   typedef struct packed {
      logic       scl1, scl2, scl3;
      logic       sda1, sda2, sda3;
      tsi_state_t st;
      logic [3:0] bitc;
      logic [7:0] sh;
      logic       first, rw, have_ptr, nack;
      logic [7:0] ptr;
      logic [7:0] wdata;
      logic       wr, oe, sdo, tmo;
      logic       st_tg, sp_tg;
      logic       to1, to2, to3;
   } tsi_main_t;

   typedef struct packed {
      logic        st1, st2, st3;
      logic        sp1, sp2, sp3;
      logic        act;
      logic [31:0] cnt;
      logic        to_tg;
   } tsi_ref_t;

   localparam tsi_main_t MAIN_RST = '{
      scl1: 1'b1, scl2: 1'b1, scl3: 1'b1,
      sda1: 1'b1, sda2: 1'b1, sda3: 1'b1,
      st: ST_IDLE, ptr: PTR_RST, default: '0};
   localparam tsi_ref_t REF_RST = '0;

endpackage : tsi_pkg

// ---- rtl/tsi_slave.sv ----
`timescale 1ns/10ps
module tsi_slave #(
   parameter int unsigned TMO_CYC = tsi_pkg::TMO_CYC
) (
   input  wire logic       mclk_i,
   input  wire logic       rstn_i,
   input  wire logic       ce_i,
   input  wire logic       ref_clk_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   output logic [7:0]      addr_o,
   output logic [7:0]      wdata_o,
   output logic            wr_o,
   input  wire logic [7:0] rd_data_i,
   output logic            tmo_o
);

   // ---------------------------------------------
   // state
   // ---------------------------------------------
   tsi_pkg::tsi_main_t s;
   tsi_pkg::tsi_main_t n;
   tsi_pkg::tsi_ref_t  r;
   tsi_pkg::tsi_ref_t  rn;

   logic rise;
   logic fall;
   logic start_ev;
   logic stop_ev;
   logic to_ev;
   logic quiet;
   logic byte_done;
   logic chg_ok;
   logic ev_st;
   logic ev_sp;

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic logic addr_hit(input logic [7:0] b);
      return {b[7:1], 1'b0} == tsi_pkg::DEV_WR;
   endfunction : addr_hit

   // next byte out, pointer advances past it
   function automatic tsi_pkg::tsi_main_t load_tx(
      input tsi_pkg::tsi_main_t v,
      input logic [7:0]         d
   );
      v.sh   = d;
      v.oe   = ~d[7];
      v.bitc = 4'h0;
      v.ptr  = v.ptr + 8'h01;
      v.st   = tsi_pkg::ST_TXB;
      return v;
   endfunction : load_tx

   // ---------------------------------------------
   // bus events
   // ---------------------------------------------
   // 20 MHz sampling gives many samples per 400 kHz phase
   assign rise     = s.scl2 & ~s.scl3;
   assign fall     = ~s.scl2 & s.scl3;
   assign start_ev = s.scl2 & s.scl3 & s.sda3 & ~s.sda2;
   assign stop_ev  = s.scl2 & s.scl3 & ~s.sda3 & s.sda2;
   assign to_ev    = s.to2 ^ s.to3;
   assign quiet    = ~start_ev & ~stop_ev & ~to_ev;
   assign byte_done = (s.st == tsi_pkg::ST_RXB) & fall
                    & (s.bitc == tsi_pkg::BYTE_LEN);
   assign chg_ok   = fall | start_ev | stop_ev | to_ev;

   // ---------------------------------------------
   // main domain
   // ---------------------------------------------
   always_comb begin
      n      = s;
      n.wr   = 1'b0;
      n.tmo  = 1'b0;
      n.scl1 = scl_i;
      n.scl2 = s.scl1;
      n.scl3 = s.scl2;
      n.sda1 = sda_i;
      n.sda2 = s.sda1;
      n.sda3 = s.sda2;
      n.to1  = r.to_tg;
      n.to2  = s.to1;
      n.to3  = s.to2;
      if (s.wr) begin
         n.ptr = s.ptr + 8'h01;
      end
      if (start_ev) begin
         // also a repeated start: restart cleanly
         n.st    = tsi_pkg::ST_RXB;
         n.bitc  = 4'h0;
         n.first = 1'b1;
         n.oe    = 1'b0;
         n.st_tg = ~s.st_tg;
      end else if (stop_ev) begin
         n.st    = tsi_pkg::ST_IDLE;
         n.oe    = 1'b0;
         n.sp_tg = ~s.sp_tg;
      end else if (to_ev && s.st != tsi_pkg::ST_IDLE) begin
         n.st  = tsi_pkg::ST_TMO;
         n.oe  = 1'b0;
         n.tmo = 1'b1;
      end else begin
         unique case (s.st)
            tsi_pkg::ST_IDLE: begin
               n.oe = 1'b0;
            end
            tsi_pkg::ST_TMO: begin
               n.oe = 1'b0;
            end
            tsi_pkg::ST_RXB: begin
               if (rise && s.bitc != tsi_pkg::BYTE_LEN) begin
                  n.sh   = {s.sh[6:0], s.sda2};
                  n.bitc = s.bitc + 4'h1;
               end else if (byte_done) begin
                  n.bitc = 4'h0;
                  if (s.first) begin
                     n.first = 1'b0;
                     if (addr_hit(s.sh)) begin
                        n.rw       = s.sh[0];
                        n.have_ptr = 1'b0;
                        n.oe       = 1'b1;
                        n.st       = tsi_pkg::ST_AOUT;
                     end else begin
                        n.st = tsi_pkg::ST_IDLE;
                     end
                  end else begin
                     n.oe = 1'b1;
                     n.st = tsi_pkg::ST_AOUT;
                     if (!s.have_ptr) begin
                        n.ptr      = s.sh;
                        n.have_ptr = 1'b1;
                     end else begin
                        n.wdata = s.sh;
                        n.wr    = 1'b1;
                     end
                  end
               end
            end
            tsi_pkg::ST_AOUT: begin
               // low held until the ack pulse falls
               if (fall) begin
                  n.oe = 1'b0;
                  if (s.rw) begin
                     n = load_tx(n, rd_data_i);
                  end else begin
                     n.st = tsi_pkg::ST_RXB;
                  end
               end
            end
            tsi_pkg::ST_TXB: begin
               if (fall) begin
                  if (s.bitc == tsi_pkg::TX_LAST) begin
                     n.oe   = 1'b0;
                     n.bitc = 4'h0;
                     n.st   = tsi_pkg::ST_AIN;
                  end else begin
                     n.sh   = {s.sh[6:0], 1'b1};
                     n.oe   = ~s.sh[6];
                     n.bitc = s.bitc + 4'h1;
                  end
               end
            end
            tsi_pkg::ST_AIN: begin
               if (rise) begin
                  n.nack = s.sda2;
               end else if (fall) begin
                  if (s.nack) begin
                     n.st = tsi_pkg::ST_IDLE;
                  end else begin
                     n = load_tx(n, rd_data_i);
                  end
               end
            end
            default: begin
               n.st = tsi_pkg::ST_IDLE;
               n.oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s <= tsi_pkg::MAIN_RST;
      end else if (ce_i) begin
         s <= n;
      end
   end

   // ---------------------------------------------
   // reference clock domain: bus timeout
   // ---------------------------------------------
   assign ev_st = r.st2 ^ r.st3;
   assign ev_sp = r.sp2 ^ r.sp3;

   always_comb begin
      rn     = r;
      rn.st1 = s.st_tg;
      rn.st2 = r.st1;
      rn.st3 = r.st2;
      rn.sp1 = s.sp_tg;
      rn.sp2 = r.sp1;
      rn.sp3 = r.sp2;
      if (ev_st) begin
         rn.act = 1'b1;
         rn.cnt = 32'h0;
      end else if (ev_sp) begin
         rn.act = 1'b0;
         rn.cnt = 32'h0;
      end else if (r.act) begin
         if (r.cnt == 32'(TMO_CYC - 1)) begin
            rn.act   = 1'b0;
            rn.cnt   = 32'h0;
            rn.to_tg = ~r.to_tg;
         end else begin
            rn.cnt = r.cnt + 32'h1;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         r <= tsi_pkg::REF_RST;
      end else begin
         r <= rn;
      end
   end

   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   assign sda_o    = s.sdo;
   assign sda_oe_o = s.oe;
   assign addr_o   = s.ptr;
   assign wdata_o  = s.wdata;
   assign wr_o     = s.wr;
   assign tmo_o    = s.tmo;

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   start_rx_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      ce_i && start_ev |=> s.st == tsi_pkg::ST_RXB && s.first)
      else $error("start not taken");

   stop_idle_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      ce_i && stop_ev && !start_ev
      |=> s.st == tsi_pkg::ST_IDLE && !sda_oe_o)
      else $error("stop not taken");

   addr_ack_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      ce_i && quiet && byte_done && s.first && addr_hit(s.sh)
      |=> sda_oe_o && s.st == tsi_pkg::ST_AOUT)
      else $error("own address not acked");

   addr_miss_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      ce_i && quiet && byte_done && s.first && !addr_hit(s.sh)
      |=> !sda_oe_o && s.st == tsi_pkg::ST_IDLE)
      else $error("foreign address answered");

   wr_inc_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      ce_i && wr_o |=> addr_o == $past(addr_o) + 8'h01)
      else $error("pointer not incremented");

   ptr_keep_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      ce_i && !wr_o && (stop_ev || to_ev) |=> $stable(addr_o))
      else $error("pointer lost on stop");

   tmo_enter_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      ce_i && to_ev && !start_ev && !stop_ev
      && s.st != tsi_pkg::ST_IDLE
      |=> s.st == tsi_pkg::ST_TMO && tmo_o ##1 !tmo_o)
      else $error("timeout not taken");

   tmo_quiet_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      s.st == tsi_pkg::ST_TMO |-> !sda_oe_o)
      else $error("drive after timeout");

   tmo_hold_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      ce_i && s.st == tsi_pkg::ST_TMO && !start_ev && !stop_ev
      |=> s.st == tsi_pkg::ST_TMO)
      else $error("left timeout without start");

   oe_edge_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      $changed(sda_oe_o) |-> $past(chg_ok))
      else $error("data changed while clock high");

   nack_free_a: assert property (
      @(posedge mclk_i) disable iff (!rstn_i)
      ce_i && quiet && s.st == tsi_pkg::ST_AIN && fall && s.nack
      |=> !sda_oe_o [*2])
      else $error("line held after nack");

   ref_tmo_a: assert property (
      @(posedge ref_clk_i) disable iff (!rstn_i)
      r.act && !ev_st && !ev_sp && r.cnt == 32'(TMO_CYC - 1)
      |=> r.to_tg != $past(r.to_tg) && !r.act)
      else $error("timeout count missed");

   wr_seen_c: cover property (
      @(posedge mclk_i) disable iff (!rstn_i) wr_o);

   rd_nack_c: cover property (
      @(posedge mclk_i) disable iff (!rstn_i)
      s.st == tsi_pkg::ST_AIN && fall && s.nack);

   tmo_seen_c: cover property (
      @(posedge mclk_i) disable iff (!rstn_i) tmo_o);

endmodule : tsi_slave

// ---- test/tsi_master.sv ----
`timescale 1ns/10ps
module tsi_master (
   input  wire logic mclk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   // ---------------------------------------------
   // bus master model, open drain on sda, scl driven both high and low
   // ---------------------------------------------
   localparam int HALF = 25;

   initial begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
   end

   task automatic hp(input int n);
      repeat (n) @(negedge mclk_i);
   endtask : hp

   // begins from idle, or repeats from mid-frame
   task automatic start;
      if (!scl_o) begin
         sda_low_o = 1'b0;
         hp(HALF);
         scl_o = 1'b1;
         hp(HALF);
      end
      sda_low_o = 1'b1;
      hp(HALF);
      scl_o = 1'b0;
   endtask : start

   task automatic stop;
      sda_low_o = 1'b1;
      hp(HALF);
      scl_o = 1'b1;
      hp(HALF);
      sda_low_o = 1'b0;
      hp(HALF);
   endtask : stop

   // data set while low, held through the high phase
   task automatic bit_io(input logic b, output logic r);
      sda_low_o = ~b;
      hp(HALF);
      scl_o = 1'b1;
      hp(HALF / 2);
      r = sda_i;
      hp(HALF - HALF / 2);
      scl_o = 1'b0;
   endtask : bit_io

   // eight bits msb first, ninth bit is acknowledge
   task automatic xfer(input logic [7:0] d, input logic ab,
                       output logic [7:0] r, output logic n);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r[i]);
      end
      bit_io(ab, n);
   endtask : xfer
endmodule : tsi_master

// ---- test/i2c_register_slave_with_timeout_bench.sv ----
`timescale 1ns/10ps
module i2c_register_slave_with_timeout_bench;
   localparam int unsigned TMO = 8000;
   logic       mclk, rstn, ref_clk, scl, sda_low, sda;
   logic       sda_o, sda_oe, wr, tmo, tmo_seen;
   logic [7:0] addr, wdata, rd_data;
   logic [7:0] mem [256];
   int         error_cnt, n_compared;

   always #25 mclk = ~mclk;
   // reference clock, offset so its edges never meet mclk edges
   initial begin
      ref_clk = 1'b0;
      #3.3;
      forever #15 ref_clk = ~ref_clk;
   end
   // pull-up wins unless someone pulls low
   assign sda     = ~(sda_low | (sda_oe & ~sda_o));
   assign rd_data = mem[addr];
   always @(posedge mclk) begin
      if (wr === 1'b1) mem[addr] <= wdata;
      if (tmo === 1'b1) tmo_seen <= 1'b1;
   end

   tsi_slave #(.TMO_CYC(TMO)) uut (
      .mclk_i(mclk), .rstn_i(rstn), .ce_i(1'b1), .ref_clk_i(ref_clk),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
      .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_data_i(rd_data),
      .tmo_o(tmo));
   tsi_master m (.mclk_i(mclk), .sda_i(sda), .scl_o(scl),
                 .sda_low_o(sda_low));

   // ---------------------------------------------
   // checking and bus helpers
   // ---------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wbyte(input logic [7:0] d, input logic ack);
      logic [7:0] r;
      logic       n;
      m.xfer(d, 1'b1, r, n);
      chk("ack", {7'h00, ~ack}, {7'h00, n});
   endtask : wbyte

   task automatic rbyte(input logic [7:0] exp, input logic last);
      logic [7:0] r;
      logic       n;
      m.xfer(8'hff, last, r, n);
      chk("read data", exp, r);
   endtask : rbyte

   task end_of_test;
      if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test

   // ---------------------------------------------
   // scenarios, each transaction kept short of the timeout except the stall in t_timeout
   // ---------------------------------------------
   task t_write;
      m.start();
      wbyte(tsi_pkg::DEV_WR, 1'b1);
      wbyte(8'h10, 1'b1);
      wbyte(8'h5a, 1'b1);
      wbyte(8'hc3, 1'b1);
      m.stop();
      chk("mem 10", 8'h5a, mem[8'h10]);
      chk("mem 11", 8'hc3, mem[8'h11]);
      chk("pointer", 8'h12, addr);
   endtask : t_write

   task t_read_rs;
      m.start();
      wbyte(tsi_pkg::DEV_WR, 1'b1);
      wbyte(8'h10, 1'b1);
      m.start();
      wbyte(tsi_pkg::DEV_RD, 1'b1);
      rbyte(8'h5a, 1'b0);
      rbyte(8'hc3, 1'b1);
      repeat (6) @(negedge mclk);
      chk("released", 8'h00, {7'h00, sda_oe});
      m.stop();
   endtask : t_read_rs

   task t_read_cont;
      m.start();
      wbyte(tsi_pkg::DEV_RD, 1'b1);
      rbyte(8'h12 ^ 8'h3c, 1'b1);
      m.stop();
   endtask : t_read_cont

   task t_foreign;
      logic [7:0] a [4] = '{8'ha4, 8'ha0, 8'h22, 8'he3};
      foreach (a[i]) begin
         m.start();
         wbyte(a[i], 1'b0);
         wbyte(8'h40, 1'b0);
         m.stop();
      end
      chk("pointer", 8'h13, addr);
   endtask : t_foreign

   task t_timeout;
      m.start();
      wbyte(tsi_pkg::DEV_WR, 1'b1);
      wbyte(8'h20, 1'b1);
      tmo_seen = 1'b0;
      repeat (TMO * 30 / 50 + 400) @(negedge mclk);
      chk("timeout", 8'h01, {7'h00, tmo_seen});
      wbyte(8'h77, 1'b0);
      rbyte(8'hff, 1'b1);
      m.stop();
      chk("mem 20", 8'h20 ^ 8'h3c, mem[8'h20]);
      m.start();
      wbyte(tsi_pkg::DEV_RD, 1'b1);
      rbyte(8'h20 ^ 8'h3c, 1'b1);
      m.stop();
   endtask : t_timeout

   initial begin
      mclk       = 1'b0;
      rstn       = 1'b0;
      tmo_seen   = 1'b0;
      error_cnt  = 0;
      n_compared = 0;
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3c;
      repeat (2) @(negedge mclk);
      rstn = 1'b1;
      repeat (4) @(negedge mclk);
      chk("reset pointer", tsi_pkg::PTR_RST, addr);
      chk("reset drive", 8'h00, {7'h00, sda_oe});
      t_write();
      t_read_rs();
      t_read_cont();
      t_foreign();
      t_timeout();
      end_of_test();
   end

   initial begin
      #2_000_000;
      error_cnt++;
      end_of_test();
   end
endmodule : i2c_register_slave_with_timeout_bench
